// ===== svof_video_formatter.sv
`timescale 1ns/1ps
module svof_video_formatter import svof_pkg::*; (
	input wire logic sys_clk,
	input wire logic rstn,
	input wire svof_fmt_t cfgFormat,
	input wire logic cfgPalNtsc,
	input wire logic busEnable,
	input wire logic pixValid,
	input wire logic [9:0] pixData,
	output logic pixTaken,
	input wire logic ctlValid,
	input wire svof_ctl_req_t ctlReq,
	output logic ctlTaken,
	output svof_pins_t vidPins
);

	////////////////////////////////////////////////////////////////////////////////
	// Declarations.

	svof_state_t state_q;
	logic [9:0] word_q;
	logic wordValid_q;
	svof_ctl_req_t req_q;
	logic [11:0] lineNum_q;
	svof_fmt_t fieldFmt_q;
	logic pixTaken_q;
	logic ctlTaken_q;
	logic lineFlag_q;
	logic fieldFlag_q;
	svof_pins_t pins_q;

	logic serReady;
	logic serBusy;
	logic [7:0] serBeat;
	logic [7:0] cmdByte;
	logic slotFree;
	logic serIdle;
	logic ctlPending;
	logic ctlGo;
	logic pixGo;
	logic load;
	logic [2:0] effCode;
	logic fieldBegin;
	logic [9:0] nextWord;
	logic [5:0] lineHi;
	logic [5:0] lineLo;

	////////////////////////////////////////////////////////////////////////////////
	// Pixel clipping keeps the escape codes out of the pixel stream in the 4- and 8-wire formats; the 5-wire clip only removes 10'h000 and 10'h3FF.

	function automatic logic [9:0] clipPixel(input svof_fmt_t f, input logic [9:0] v);
		logic [7:0] top;
		top = v[PIX_W-1 -: BYTE_W];
		if (f == SVOF_FMT_5W) begin
			if (v < PIX10_MIN) begin
				clipPixel = PIX10_MIN;
			end else if (v > PIX10_MAX) begin
				clipPixel = PIX10_MAX;
			end else begin
				clipPixel = v;
			end
		end else begin
			if (top < PIX8_MIN) begin
				top = PIX8_MIN;
			end else if (top > PIX8_MAX) begin
				top = PIX8_MAX;
			end
			clipPixel = {top, LOW_PAD};
		end
	endfunction : clipPixel

	////////////////////////////////////////////////////////////////////////////////
	// Request arbitration.

	assign slotFree = !wordValid_q || serReady;
	assign serIdle = !wordValid_q && !serBusy;
	assign ctlPending = ctlValid && !ctlTaken_q;

	// Odd field codes fall back to even ones outside the interlaced modes.
	always_comb begin
		effCode = ctlReq.code;
		if (ctlReq.isEnd) begin
			effCode = END_OF_LINE_CODE;
		end else if (!cfgPalNtsc && ctlReq.code == ODD_FIELD_BEGIN_CODE) begin
			effCode = EVEN_FIELD_BEGIN_CODE;
		end else if (!cfgPalNtsc && ctlReq.code == ODD_FIELD_FINISH_CODE) begin
			effCode = EVEN_FIELD_FINISH_CODE;
		end
	end

	assign fieldBegin = !ctlReq.isEnd && (effCode == EVEN_FIELD_BEGIN_CODE || effCode == ODD_FIELD_BEGIN_CODE);

	// A field start waits for the serializer to drain so the format switch never splits a word.
	assign ctlGo = (state_q == ST_IDLE) && ctlPending && slotFree && (!fieldBegin || serIdle);
	assign pixGo = (state_q == ST_IDLE) && !ctlPending && pixValid && !pixTaken_q && slotFree;
	assign load = pixGo || ((state_q != ST_IDLE) && slotFree);

	////////////////////////////////////////////////////////////////////////////////
	// Word selection for each step of a control sequence.

	assign lineHi = lineNum_q[LNUM_W-1 -: HALF_W];
	assign lineLo = lineNum_q[HALF_W-1:0];

	svof_cmd_encoder u_cmd (
		.ctlBits(req_q.code),
		.cmdByte(cmdByte)
	);

	always_comb begin
		nextWord = {NULL_BYTE, LOW_PAD};
		case (state_q)
			ST_ESC1: begin
				nextWord = {ESC_BYTE, LOW_PAD};
			end
			ST_ESC2: begin
				nextWord = {ESC_BYTE, LOW_PAD};
			end
			ST_SYNC: begin
				nextWord = {SYNC_BYTE, LOW_PAD};
			end
			ST_CMD: begin
				nextWord = {cmdByte, LOW_PAD};
			end
			ST_SUP1: begin
				if (req_q.isEnd) begin
					nextWord = {req_q.average[PIX_W-1 -: BYTE_W], LOW_PAD};
				end else begin
					nextWord = {SUP_LEAD, lineHi, ~^lineHi, LOW_PAD};
				end
			end
			ST_SUP2: begin
				if (req_q.isEnd) begin
					nextWord = {TRAIL_BYTE, LOW_PAD};
				end else begin
					nextWord = {SUP_LEAD, lineLo, ~^lineLo, LOW_PAD};
				end
			end
			ST_IDLE: begin
				nextWord = clipPixel(fieldFmt_q, pixData);
			end
			default: begin
				nextWord = {NULL_BYTE, LOW_PAD};
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////////////
	// Sequence state.

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			state_q <= ST_IDLE;
		end else begin
			case (state_q)
				ST_IDLE: begin
					if (ctlGo) begin
						state_q <= ST_ESC1;
					end
				end
				ST_ESC1: begin
					if (slotFree) begin
						state_q <= ST_ESC2;
					end
				end
				ST_ESC2: begin
					if (slotFree) begin
						state_q <= ST_SYNC;
					end
				end
				ST_SYNC: begin
					if (slotFree) begin
						state_q <= ST_CMD;
					end
				end
				ST_CMD: begin
					if (slotFree) begin
						state_q <= ST_SUP1;
					end
				end
				ST_SUP1: begin
					if (slotFree) begin
						state_q <= ST_SUP2;
					end
				end
				ST_SUP2: begin
					if (slotFree) begin
						state_q <= ST_IDLE;
					end
				end
				default: begin
					state_q <= ST_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			word_q <= 10'h000;
			wordValid_q <= 1'b0;
		end else if (load) begin
			word_q <= nextWord;
			wordValid_q <= 1'b1;
		end else if (serReady) begin
			wordValid_q <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			req_q <= '0;
		end else if (ctlGo) begin
			req_q.isEnd <= ctlReq.isEnd;
			req_q.code <= effCode;
			req_q.average <= ctlReq.average;
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			lineNum_q <= LNUM_FIRST;
		end else if (ctlGo && fieldBegin) begin
			lineNum_q <= LNUM_FIRST;
		end else if (ctlGo && !ctlReq.isEnd) begin
			lineNum_q <= lineNum_q + LNUM_STEP;
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			fieldFmt_q <= SVOF_FMT_5W;
		end else if (ctlGo && fieldBegin) begin
			fieldFmt_q <= cfgFormat;
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			pixTaken_q <= 1'b0;
			ctlTaken_q <= 1'b0;
		end else begin
			pixTaken_q <= pixGo;
			ctlTaken_q <= ctlGo;
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			lineFlag_q <= 1'b0;
			fieldFlag_q <= 1'b0;
		end else if (ctlGo) begin
			lineFlag_q <= !ctlReq.isEnd;
			fieldFlag_q <= fieldBegin;
		end else if (state_q == ST_SUP2 && slotFree) begin
			lineFlag_q <= 1'b0;
			fieldFlag_q <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Serializer and pin register.

	svof_nibble_serializer u_ser (
		.sys_clk(sys_clk),
		.rstn(rstn),
		.fmt(fieldFmt_q),
		.wordIn(word_q),
		.wordValid(wordValid_q),
		.wordReady(serReady),
		.busy(serBusy),
		.beat(serBeat)
	);

	// In the 8-wire format the indicator pins carry data bits instead.
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			pins_q <= '0;
		end else begin
			pins_q.data <= serBeat[4:0];
			pins_q.oe <= !busEnable ? OE_NONE : (fieldFmt_q == SVOF_FMT_4W) ? OE_4W : OE_ALL;
			if (fieldFmt_q == SVOF_FMT_8W) begin
				pins_q.fieldPin <= serBeat[BIT_FIELD_PIN];
				pins_q.linePin <= serBeat[BIT_LINE_PIN];
				pins_q.topPin <= serBeat[BIT_TOP_PIN];
			end else begin
				pins_q.fieldPin <= fieldFlag_q;
				pins_q.linePin <= lineFlag_q;
				pins_q.topPin <= 1'b0;
			end
		end
	end

	assign vidPins = pins_q;
	assign pixTaken = pixTaken_q;
	assign ctlTaken = ctlTaken_q;

	////////////////////////////////////////////////////////////////////////////////
	// Checks.

	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rstn);

	a_pixel_clip_range: assert property (pixGo |=> word_q >= PIX10_MIN && word_q <= PIX10_MAX &&
		(fieldFmt_q == SVOF_FMT_5W || (word_q[9:2] <= PIX8_MAX && word_q[1:0] == LOW_PAD)))
		else $error("pixel word outside clip range");

	a_escape_prefix_word: assert property (load && (state_q == ST_ESC1 || state_q == ST_ESC2)
		|=> word_q == {ESC_BYTE, LOW_PAD})
		else $error("escape word is not all ones");

	a_sync_zero_word: assert property (load && state_q == ST_SYNC |=> word_q == {SYNC_BYTE, LOW_PAD})
		else $error("sync word is not all zeros");

	a_cmd_mark_pad: assert property (load && state_q == ST_CMD |=> word_q[9] && word_q[1:0] == LOW_PAD)
		else $error("command word mark or padding wrong");

	a_cmd_even_parity: assert property (load && state_q == ST_CMD |=>
		!(^{word_q[8:6], word_q[2]}) && !(^{word_q[8:7], word_q[3]}) &&
		!(^{word_q[8], word_q[6], word_q[4]}) && !(^{word_q[7:6], word_q[5]}))
		else $error("command check bits not even");

	a_linenum_odd_parity: assert property (load && (state_q == ST_SUP1 || state_q == ST_SUP2) && !req_q.isEnd
		|=> !word_q[9] && (^word_q[8:2]))
		else $error("line number half lacks odd parity");

	a_closing_trailer: assert property (load && state_q == ST_SUP2 && req_q.isEnd
		|=> word_q == {TRAIL_BYTE, LOW_PAD})
		else $error("closing sequence trailer not all ones");

	a_odd_code_gated: assert property (ctlGo && !cfgPalNtsc |=>
		req_q.code != ODD_FIELD_BEGIN_CODE && req_q.code != ODD_FIELD_FINISH_CODE)
		else $error("odd field code outside interlaced mode");

	a_format_held_field: assert property (!$stable(fieldFmt_q) |-> ctlTaken_q && fieldFlag_q)
		else $error("format changed outside a field start");

	a_sequence_six_words: assert property (ctlGo |=> state_q == ST_ESC1 ##1
		(state_q != ST_IDLE) [*5])
		else $error("control sequence shorter than six words");

	a_linenum_restart: assert property (ctlGo && fieldBegin |=> lineNum_q == LNUM_FIRST)
		else $error("line number not reset at field start");

	a_four_wire_lanes: assert property (fieldFmt_q == SVOF_FMT_4W && $stable(fieldFmt_q) |=> !pins_q.oe[4])
		else $error("upper wire driven in 4-wire format");

	c_closing_sequence: cover property (ctlGo && ctlReq.isEnd ##[1:40] state_q == ST_SUP2 && slotFree);
	c_field_begin: cover property (ctlGo && fieldBegin);
	c_pixel_byte_mode: cover property (pixGo && fieldFmt_q == SVOF_FMT_8W);

endmodule : svof_video_formatter

// ===== svof_pkg.sv
package svof_pkg;

	typedef enum logic [1:0] {
		SVOF_FMT_5W = 2'h0,
		SVOF_FMT_4W = 2'h1,
		SVOF_FMT_8W = 2'h2
	} svof_fmt_t;

	typedef enum logic [6:0] {
		ST_IDLE = 7'h01,
		ST_ESC1 = 7'h02,
		ST_ESC2 = 7'h04,
		ST_SYNC = 7'h08,
		ST_CMD = 7'h10,
		ST_SUP1 = 7'h20,
		ST_SUP2 = 7'h40
	} svof_state_t;

	localparam int PIX_W = 10;
	localparam int BYTE_W = 8;
	localparam int LNUM_W = 12;
	localparam int HALF_W = 6;
	localparam int BIT_FIELD_PIN = 5;
	localparam int BIT_LINE_PIN = 6;
	localparam int BIT_TOP_PIN = 7;

	localparam logic [2:0] END_OF_LINE_CODE = 3'h0;
	localparam logic [2:0] EMPTY_LINE_CODE = 3'h1;
	localparam logic [2:0] DARK_REFERENCE_LINE_CODE = 3'h2;
	localparam logic [2:0] IMAGE_LINE_CODE = 3'h3;
	localparam logic [2:0] EVEN_FIELD_BEGIN_CODE = 3'h4;
	localparam logic [2:0] EVEN_FIELD_FINISH_CODE = 3'h5;
	localparam logic [2:0] ODD_FIELD_BEGIN_CODE = 3'h6;
	localparam logic [2:0] ODD_FIELD_FINISH_CODE = 3'h7;

	localparam logic [7:0] ESC_BYTE = 8'hFF;
	localparam logic [7:0] SYNC_BYTE = 8'h00;
	localparam logic [7:0] TRAIL_BYTE = 8'hFF;
	localparam logic [7:0] NULL_BYTE = 8'h00;
	localparam logic [1:0] LOW_PAD = 2'h0;
	localparam logic CMD_MARK = 1'b1;
	localparam logic SUP_LEAD = 1'b0;
	localparam logic [9:0] PIX10_MIN = 10'h001;
	localparam logic [9:0] PIX10_MAX = 10'h3FE;
	localparam logic [7:0] PIX8_MIN = 8'h01;
	localparam logic [7:0] PIX8_MAX = 8'hFE;
	localparam logic [4:0] OE_NONE = 5'h00;
	localparam logic [4:0] OE_4W = 5'h0F;
	localparam logic [4:0] OE_ALL = 5'h1F;
	localparam logic [11:0] LNUM_FIRST = 12'h000;
	localparam logic [11:0] LNUM_STEP = 12'h001;

	typedef struct packed {
		logic isEnd;
		logic [2:0] code;
		logic [9:0] average;
	} svof_ctl_req_t;

	typedef struct packed {
		logic [4:0] data;
		logic [4:0] oe;
		logic fieldPin;
		logic linePin;
		logic topPin;
	} svof_pins_t;

endpackage : svof_pkg

// ===== svof_cmd_encoder.sv
`timescale 1ns/1ps
module svof_cmd_encoder import svof_pkg::*; (
	input wire logic [2:0] ctlBits,
	output logic [7:0] cmdByte
);
	logic [3:0] check;

	assign check[0] = ^ctlBits;
	assign check[1] = ctlBits[2] ^ ctlBits[1];
	assign check[2] = ctlBits[2] ^ ctlBits[0];
	assign check[3] = ctlBits[1] ^ ctlBits[0];
	assign cmdByte = {CMD_MARK, ctlBits, check};
endmodule : svof_cmd_encoder

// ===== svof_nibble_serializer.sv
`timescale 1ns/1ps
module svof_nibble_serializer import svof_pkg::*; (
	input wire logic sys_clk,
	input wire logic rstn,
	input wire svof_fmt_t fmt,
	input wire logic [9:0] wordIn,
	input wire logic wordValid,
	output logic wordReady,
	output logic busy,
	output logic [7:0] beat
);
	logic [9:0] hold_q;
	logic phase_q;
	logic busy_q;
	logic lastBeat;

	assign lastBeat = (fmt == SVOF_FMT_8W) || phase_q;
	assign wordReady = !busy_q || lastBeat;
	assign busy = busy_q;

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			hold_q <= 10'h000;
			busy_q <= 1'b0;
			phase_q <= 1'b0;
		end else if (wordValid && wordReady) begin
			hold_q <= wordIn;
			busy_q <= 1'b1;
			phase_q <= 1'b0;
		end else if (busy_q && lastBeat) begin
			busy_q <= 1'b0;
			phase_q <= 1'b0;
		end else if (busy_q) begin
			phase_q <= 1'b1;
		end
	end

	// Idle cycles carry null bytes, which the host skips between lines.
	always_comb begin
		beat = NULL_BYTE;
		if (busy_q) begin
			case (fmt)
				SVOF_FMT_5W: beat = phase_q ? {3'h0, hold_q[4:0]} : {3'h0, hold_q[9:5]};
				SVOF_FMT_4W: beat = phase_q ? {4'h0, hold_q[5:2]} : {4'h0, hold_q[9:6]};
				default: beat = hold_q[PIX_W-1 -: BYTE_W];
			endcase
		end
	end
endmodule : svof_nibble_serializer

// ===== svof_host_model.sv
`timescale 1ns/1ps
module svof_host_model import svof_pkg::*; (
	input wire logic sys_clk,
	input wire logic rstn,
	input wire svof_fmt_t fmt,
	input wire svof_pins_t vidPins,
	output logic [7:0] beat,
	output logic [7:0] cmdFixed,
	output logic cmdDouble
);
	logic [55:0] hist_q;
	logic [7:0] now;
	logic [7:0] cmd;
	logic [3:0] syn;
	logic found;

	function automatic logic [7:0] wb(input logic [7:0] a, input logic [7:0] b);
		if (fmt == SVOF_FMT_5W) begin
			return {a[4:0], b[4:2]};
		end
		return {a[3:0], b[3:0]};
	endfunction : wb

	assign now = (fmt == SVOF_FMT_8W) ? {vidPins.topPin, vidPins.linePin, vidPins.fieldPin, vidPins.data} :
		{3'h0, vidPins.data};

	////////////////////////////////////////////////////////////////
	// Word boundaries come from the escape prefix, so nulls between lines do no harm.
	always_comb begin
		if (fmt == SVOF_FMT_8W) begin
			cmd = now;
			found = hist_q[23:0] == 24'hFF_FF00;
		end else begin
			cmd = wb(hist_q[7:0], now);
			found = wb(hist_q[23:16], hist_q[15:8]) == 8'h00 && wb(hist_q[39:32], hist_q[31:24]) == 8'hFF &&
				wb(hist_q[55:48], hist_q[47:40]) == 8'hFF;
		end
		syn = {^{cmd[5:4], cmd[3]}, ^{cmd[6], cmd[4], cmd[2]}, ^{cmd[6:5], cmd[1]}, ^{cmd[6:4], cmd[0]}};
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			hist_q <= '0;
			beat <= 8'h00;
			cmdFixed <= 8'h00;
			cmdDouble <= 1'b0;
		end else begin
			hist_q <= {hist_q[47:0], now};
			beat <= now;
			if (found) begin
				cmdDouble <= 1'b0;
				case (syn)
					4'hD: cmdFixed <= cmd ^ 8'h10;
					4'hB: cmdFixed <= cmd ^ 8'h20;
					4'h7: cmdFixed <= cmd ^ 8'h40;
					4'h0, 4'h1, 4'h2, 4'h4, 4'h8: cmdFixed <= cmd;
					default: cmdDouble <= 1'b1;
				endcase
			end
		end
	end
endmodule : svof_host_model

// ===== tb.sv
`timescale 1ns/1ps
module tb import svof_pkg::*; ;
	typedef struct packed {
		svof_fmt_t fmt;
		logic [9:0] pix;
		logic [7:0] e0;
		logic [7:0] e1;
	} svof_row_t;
	logic sys_clk = 1'b0;
	logic rstn, cfgPalNtsc, busEnable, pixValid, pixTaken, ctlValid, ctlTaken, cmdDouble;
	logic [9:0] pixData;
	logic [7:0] beat, cmdFixed;
	logic [2:0] lc;
	svof_fmt_t cfgFormat, curFmt;
	svof_ctl_req_t ctlReq;
	svof_pins_t vidPins;
	logic [7:0] expq[$];
	int err_count = 0;
	int total_checks = 0;
	logic [2:0] codes [5] = '{EMPTY_LINE_CODE, DARK_REFERENCE_LINE_CODE, IMAGE_LINE_CODE, EVEN_FIELD_FINISH_CODE,
		ODD_FIELD_FINISH_CODE};
	// Each row is a raw sample, its wire format and the beats a receiver should see.
	svof_row_t rows [9] = '{
		'{SVOF_FMT_5W, 10'h3FF, 8'h1F, 8'h1E}, '{SVOF_FMT_5W, 10'h000, 8'h00, 8'h01},
		'{SVOF_FMT_5W, 10'h2A5, 8'h15, 8'h05}, '{SVOF_FMT_4W, 10'h3FF, 8'h0F, 8'h0E},
		'{SVOF_FMT_4W, 10'h123, 8'h04, 8'h08}, '{SVOF_FMT_4W, 10'h000, 8'h00, 8'h01},
		'{SVOF_FMT_8W, 10'h3FF, 8'hFE, 8'h00}, '{SVOF_FMT_8W, 10'h000, 8'h01, 8'h00},
		'{SVOF_FMT_8W, 10'h2C4, 8'hB1, 8'h00}};

	svof_video_formatter dut_u (.sys_clk(sys_clk), .rstn(rstn), .cfgFormat(cfgFormat), .cfgPalNtsc(cfgPalNtsc),
		.busEnable(busEnable), .pixValid(pixValid), .pixData(pixData), .pixTaken(pixTaken), .ctlValid(ctlValid),
		.ctlReq(ctlReq), .ctlTaken(ctlTaken), .vidPins(vidPins));
	svof_host_model host_u (.sys_clk(sys_clk), .rstn(rstn), .fmt(curFmt), .vidPins(vidPins), .beat(beat),
		.cmdFixed(cmdFixed), .cmdDouble(cmdDouble));

	always #2.5 sys_clk = ~sys_clk;

	////////////////////////////////////////////////////////////////
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : report_and_stop

	task automatic hang();
		err_count++;
		$display("BAD t=%0t wait expired got 0 exp 1", $time);
		report_and_stop();
	endtask : hang

	task automatic chk_val(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp) begin
			err_count++;
			$display("BAD t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk_val

	task automatic chk_pins(input svof_pins_t got, input svof_pins_t exp);
		total_checks++;
		if (got !== exp) begin
			err_count++;
			$display("BAD t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk_pins

	task automatic done(input string name);
		$display("test %s done", name);
	endtask : done

	function automatic logic [7:0] cmd_of(input logic [2:0] c);
		return {1'b1, c, c[1] ^ c[0], c[2] ^ c[0], c[2] ^ c[1], ^c};
	endfunction : cmd_of

	function automatic logic [7:0] half(input logic [5:0] h);
		return {1'b0, h, ~^h};
	endfunction : half

	task automatic push_word(input logic [9:0] w);
		case (curFmt)
			SVOF_FMT_5W: begin
				expq.push_back({3'h0, w[9:5]});
				expq.push_back({3'h0, w[4:0]});
			end
			SVOF_FMT_4W: begin
				expq.push_back({4'h0, w[9:6]});
				expq.push_back({4'h0, w[5:2]});
			end
			default: expq.push_back(w[9:2]);
		endcase
	endtask : push_word

	task automatic send(input logic isCtl);
		int k;
		k = 0;
		ctlValid = isCtl;
		pixValid = !isCtl;
		do begin
			@(negedge sys_clk);
			k++;
		end while (k < 50 && (isCtl ? ctlTaken : pixTaken) !== 1'b1);
		ctlValid = 1'b0;
		pixValid = 1'b0;
		pixData = ~pixData;
		if (k == 50) hang();
	endtask : send

	// Idle beats are null, so the stream is compared from its first nonzero beat on.
	task automatic check_stream();
		int k;
		k = 0;
		while (expq.size() > 0 && expq[0] === 8'h00) begin
			void'(expq.pop_front());
		end
		while (beat === 8'h00 && k < 60) begin
			@(negedge sys_clk);
			k++;
		end
		if (k == 60) hang();
		while (expq.size() > 0) begin
			chk_val(beat, expq.pop_front());
			@(negedge sys_clk);
		end
	endtask : check_stream

	task automatic ctl(input logic isEnd, input logic [2:0] code, input logic [9:0] avg, input logic [7:0] c,
		input logic [7:0] s1, input logic [7:0] s2);
		logic [7:0] w [6];
		w = '{8'hFF, 8'hFF, 8'h00, c, s1, s2};
		foreach (w[i]) begin
			push_word({w[i], 2'h0});
		end
		ctlReq = '{isEnd, code, avg};
		send(1'b1);
		repeat (2) @(negedge sys_clk);
		if (curFmt != SVOF_FMT_8W) begin
			chk_val({6'h00, vidPins.fieldPin, vidPins.linePin}, {6'h00, !isEnd && code[2] && !code[0], !isEnd});
		end
		chk_val({3'h0, vidPins.oe}, {3'h0, (curFmt == SVOF_FMT_4W) ? OE_4W : OE_ALL});
		check_stream();
		chk_val(cmdFixed, c);
		chk_val({7'h00, cmdDouble}, 8'h00);
	endtask : ctl

	task automatic field(input svof_fmt_t f, input logic [2:0] code, input logic [2:0] sent);
		cfgFormat = f;
		curFmt = f;
		ctl(1'b0, code, 10'h000, cmd_of(sent), half(6'h00), half(6'h00));
		cfgFormat = (f == SVOF_FMT_5W) ? SVOF_FMT_8W : SVOF_FMT_5W;
	endtask : field

	////////////////////////////////////////////////////////////////
	initial begin
		rstn = 1'b0;
		cfgFormat = SVOF_FMT_5W;
		curFmt = SVOF_FMT_5W;
		cfgPalNtsc = 1'b1;
		busEnable = 1'b1;
		pixValid = 1'b0;
		ctlValid = 1'b0;
		pixData = 10'h000;
		ctlReq = '0;
		repeat (3) @(negedge sys_clk);
		chk_pins(vidPins, '0);
		rstn = 1'b1;
		done("reset");
		foreach (rows[i]) begin
			if (i == 0 || rows[i].fmt !== curFmt) field(rows[i].fmt, EVEN_FIELD_BEGIN_CODE, EVEN_FIELD_BEGIN_CODE);
			pixData = rows[i].pix;
			expq.push_back(rows[i].e0);
			if (rows[i].fmt != SVOF_FMT_8W) expq.push_back(rows[i].e1);
			send(1'b0);
			check_stream();
		end
		done("pixel rows");
		field(SVOF_FMT_4W, ODD_FIELD_BEGIN_CODE, ODD_FIELD_BEGIN_CODE);
		for (int n = 1; n < 67; n++) begin
			lc = codes[n % 5];
			ctl(1'b0, lc, 10'h000, cmd_of(lc), half(n[11:6]), half(n[5:0]));
		end
		ctl(1'b1, 3'h7, 10'h2D7, 8'h80, 8'hB5, 8'hFF);
		done("line numbers");
		busEnable = 1'b0;
		repeat (2) @(negedge sys_clk);
		chk_val({3'h0, vidPins.oe}, {3'h0, OE_NONE});
		busEnable = 1'b1;
		repeat (2) @(negedge sys_clk);
		chk_val({3'h0, vidPins.oe}, {3'h0, OE_4W});
		done("bus enable");
		cfgPalNtsc = 1'b0;
		field(SVOF_FMT_8W, ODD_FIELD_BEGIN_CODE, EVEN_FIELD_BEGIN_CODE);
		ctl(1'b0, ODD_FIELD_FINISH_CODE, 10'h000, cmd_of(EVEN_FIELD_FINISH_CODE), half(6'h00), half(6'h01));
		done("odd remap");
		ctlReq = '{1'b0, IMAGE_LINE_CODE, 10'h000};
		send(1'b1);
		repeat (3) @(negedge sys_clk);
		rstn = 1'b0;
		@(negedge sys_clk);
		chk_pins(vidPins, '0);
		rstn = 1'b1;
		curFmt = SVOF_FMT_5W;
		pixData = 10'h2A5;
		expq = '{8'h15, 8'h05};
		send(1'b0);
		check_stream();
		done("mid reset");
		report_and_stop();
	end
endmodule : tb
